// File: shared/supervisor_pkg.sv
// constants for the supply supervisor control block
package supervisor_pkg;
  // register index 0x56 is not a multiple of four: byte address is index times four
  localparam logic [7:0]  CTRL_INDEX      = 8'h56;
  localparam logic [11:0] CTRL_ADDR       = {2'b00, CTRL_INDEX, 2'b00};
  localparam logic [11:0] IRQ_STATUS_ADDR = 12'h160;
  localparam logic [11:0] IRQ_MASK_ADDR   = 12'h164;
  localparam int          LEVEL_MSB       = 7;
  localparam int          LEVEL_LSB       = 4;
  localparam int          RESET_ON_FLAG_ENABLE_BIT       = 3;
  localparam int          ACTIVE_BIT      = 2;
  localparam int          CMP_BIT         = 1;
  localparam int          FLAG_BIT        = 0;
  localparam logic [3:0]  LEVEL_OFF       = 4'h0;
  localparam logic [3:0]  LEVEL_EXTERNAL  = 4'hF;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [2:0]  IRQ_RESET       = 3'h0;
  // interrupt bits: flag set, settling done, reset requested
  localparam int          IRQ_FLAG_BIT    = 0;
  localparam int          IRQ_READY_BIT   = 1;
  localparam int          IRQ_POR_BIT     = 2;
  localparam int          CLK_MHZ         = 50;
  localparam int          SETTLE_US       = 50;
  localparam int          SETTLE_CYCLES   = SETTLE_US * CLK_MHZ;
  localparam logic [11:0] SETTLE_LAST     = 12'(SETTLE_CYCLES - 1);
  typedef enum logic [1:0]
  {
    ST_OFF    = 2'b00,
    ST_SETTLE = 2'b01,
    ST_ACTIVE = 2'b10
  } sup_state_t;
endpackage

// File: hdl/supply_supervisor_control.sv
// supply supervisor control register, settling delay and reset request
// Function
// - level zero disables, nonzero enables supervisor
// - levels 1..14 pick comparator threshold
// - level 15 routes external sense input, except on single level parts
// - monitor active bit is read only
// - comparator low sets low voltage flag
// - enable bit makes flag request reset
// - flag sticky until software writes zero
// - clear during low condition sets again
// - zero to nonzero level starts settle delay
// - during settle: inactive, no flag, no reset
// - write while inactive aborts settle delay
// - nonzero level change starts no delay
// - only brownout reset clears control register
// - comparator bit shows live comparator output
// - level field is bits seven to four
// - single level parts: any nonzero same threshold
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_control
  import supervisor_pkg::*;
#(
  parameter bit SINGLE_LEVEL = 1'b0
)
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        brownout_reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        comparator_low,
  output logic             comparator_enable,
  output logic [3:0]       threshold_select,
  output logic             external_sense_select,
  output logic             por_request,
  output logic             irq
);

  logic [7:0]  ctrl_reg;
  logic        cmp_meta_reg;
  logic        cmp_sync_reg;
  sup_state_t  state_reg;
  logic [11:0] settle_cnt_reg;
  logic [2:0]  irq_status_reg;
  logic [2:0]  irq_mask_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;

  logic [3:0]  level;
  logic        access;
  logic        ctrl_wr;
  logic        ctrl_rd_stat;
  logic        active;
  logic        flag_set;
  logic        settle_done;
  logic        por_next;
  logic        por_reg;
  logic [3:0]  level_next;

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == CTRL_ADDR) || (a == IRQ_STATUS_ADDR) || (a == IRQ_MASK_ADDR);
  endfunction

  assign level        = ctrl_reg[LEVEL_MSB:LEVEL_LSB];
  assign access       = psel && penable && !pready_reg;
  assign ctrl_wr      = access && pwrite && (paddr == CTRL_ADDR);
  assign ctrl_rd_stat = access && !pwrite && (paddr == IRQ_STATUS_ADDR);
  assign level_next   = pwdata[LEVEL_MSB:LEVEL_LSB];
  assign active       = (state_reg == ST_ACTIVE);
  // flag only raised by a monitoring supervisor, never while settling
  assign flag_set     = active && cmp_sync_reg;
  assign settle_done  = (state_reg == ST_SETTLE) && (settle_cnt_reg == SETTLE_LAST);
  assign por_next     = flag_set && ctrl_reg[RESET_ON_FLAG_ENABLE_BIT];

  // the analog output is asynchronous; only the second flop is read
  always_ff @(posedge ref_clk)
  begin
    cmp_meta_reg <= comparator_low;
    cmp_sync_reg <= cmp_meta_reg;
  end

  // srst is a power-up clear class reset and leaves the register alone
  always_ff @(posedge ref_clk)
  begin
    if (brownout_reset)
      ctrl_reg <= CTRL_RESET;
    else
    begin
      if (ctrl_wr)
      begin
        ctrl_reg[LEVEL_MSB:LEVEL_LSB] <= level_next;
        ctrl_reg[RESET_ON_FLAG_ENABLE_BIT]           <= pwdata[RESET_ON_FLAG_ENABLE_BIT];
        // write of zero clears; a present low condition wins and sets again
        ctrl_reg[FLAG_BIT]            <= pwdata[FLAG_BIT] | ctrl_reg[FLAG_BIT] | flag_set;
        if (!pwdata[FLAG_BIT])
          ctrl_reg[FLAG_BIT] <= flag_set;
      end
      else if (flag_set)
        ctrl_reg[FLAG_BIT] <= 1'b1;
      ctrl_reg[ACTIVE_BIT] <= 1'b0;
      ctrl_reg[CMP_BIT]    <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (brownout_reset)
    begin
      state_reg      <= ST_OFF;
      settle_cnt_reg <= 12'h000;
    end
    else
    begin
      settle_cnt_reg <= 12'h000;
      unique case (state_reg)
        ST_OFF:
          if (ctrl_wr && level_next != LEVEL_OFF)
            state_reg <= ST_SETTLE;
        ST_SETTLE:
          if (ctrl_wr && level_next == LEVEL_OFF)
            state_reg <= ST_OFF;
          else if (ctrl_wr || settle_done)
            state_reg <= ST_ACTIVE;
          else
            settle_cnt_reg <= settle_cnt_reg + 12'h001;
        ST_ACTIVE:
          if (ctrl_wr && level_next == LEVEL_OFF)
            state_reg <= ST_OFF;
        default:
          state_reg <= ST_OFF;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (brownout_reset || srst)
    begin
      comparator_enable     <= 1'b0;
      threshold_select      <= LEVEL_OFF;
      external_sense_select <= 1'b0;
      por_reg               <= 1'b0;
    end
    else
    begin
      comparator_enable     <= (level != LEVEL_OFF);
      threshold_select      <= (SINGLE_LEVEL && level != LEVEL_OFF) ? 4'h1 : level;
      external_sense_select <= !SINGLE_LEVEL && (level == LEVEL_EXTERNAL);
      por_reg               <= por_next;
    end
  end
  assign por_request = por_reg;

  // status bits: set wins over the clearing read
  always_ff @(posedge ref_clk)
  begin
    if (srst || brownout_reset)
    begin
      irq_status_reg <= IRQ_RESET;
      irq_mask_reg   <= IRQ_RESET;
      irq            <= 1'b0;
    end
    else
    begin
      irq_status_reg <= (ctrl_rd_stat ? IRQ_RESET : irq_status_reg)
                        | {por_next, settle_done, flag_set && !ctrl_reg[FLAG_BIT]};
      if (access && pwrite && paddr == IRQ_MASK_ADDR)
        irq_mask_reg <= pwdata[2:0];
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // one wait state: access phase answered on its second cycle
  always_ff @(posedge ref_clk)
  begin
    if (srst || brownout_reset)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= access;
      pslverr_reg <= access && !addr_mapped(paddr);
      prdata_reg  <= 32'h0000_0000;
      if (access && !pwrite)
        unique case (paddr)
          CTRL_ADDR:
            prdata_reg[7:0] <= {level, ctrl_reg[RESET_ON_FLAG_ENABLE_BIT], active, cmp_sync_reg,
                                ctrl_reg[FLAG_BIT]};
          IRQ_STATUS_ADDR:
            prdata_reg[2:0] <= irq_status_reg;
          IRQ_MASK_ADDR:
            prdata_reg[2:0] <= irq_mask_reg;
          default:
            prdata_reg <= 32'h0000_0000;
        endcase
    end
  end
  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

endmodule
`default_nettype wire

// File: bench/supervisor_asserts.sv
// concurrent checks on the supply supervisor control ports
`timescale 1ns/1ps
`default_nettype none
module supervisor_asserts
  import supervisor_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       brownout_reset,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       comparator_low,
  input wire logic       comparator_enable,
  input wire logic [3:0] threshold_select,
  input wire logic       external_sense_select,
  input wire logic       por_request
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst || brownout_reset);
  a_ready_one_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_level_enable: assert property (comparator_enable == (threshold_select != LEVEL_OFF))
    else $error("enable does not follow level");
  a_ext_route: assert property (external_sense_select |-> threshold_select == LEVEL_EXTERNAL)
    else $error("external sense without top level");
  a_por_enabled: assert property (por_request |-> comparator_enable)
    else $error("reset request while off");
  // two sync flops plus the output register put the cause three cycles back
  a_por_cause: assert property (por_request |-> $past(comparator_low, 2)
    || $past(comparator_low, 3) || $past(comparator_low, 4))
    else $error("reset request without comparator low");
  a_settle_quiet: assert property ($rose(comparator_enable) |-> !por_request [*8])
    else $error("reset request during settling");
  // the output register refills one cycle after srst ends, so skip two cycles
  a_level_by_write: assert property ($changed(threshold_select) && !$past(srst) && !$past(srst, 2)
    |-> $past(psel && penable))
    else $error("level changed without a write");
  c_por: cover property (por_request);
  c_ext: cover property (external_sense_select);
  c_settle: cover property ($rose(comparator_enable));
endmodule
bind supply_supervisor_control supervisor_asserts chk (.ref_clk, .srst, .brownout_reset,
  .psel, .penable, .pready, .comparator_low, .comparator_enable, .threshold_select,
  .external_sense_select, .por_request);
`default_nettype wire

// File: bench/comparator_model.sv
// behavioural analog comparator facing the supervisor
`timescale 1ns/1ps
`default_nettype none
module comparator_model
(
  input wire logic       comparator_enable,
  input wire logic [3:0] threshold_select,
  input wire logic       external_sense_select,
  input wire logic [3:0] supply_level,
  input wire logic       ext_low,
  output logic           comparator_low
);
  // a powered-down comparator never drives comparator_low high; no hysteresis is modelled
  assign comparator_low = comparator_enable
    && (external_sense_select ? ext_low : (supply_level < threshold_select));
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the supply supervisor control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import supervisor_pkg::*;
();
  logic        ref_clk = 1'b0, srst = 1'b1, brownout_reset = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_low = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  supply = 4'hF, threshold_select;
  logic        pready, pslverr, comparator_low, comparator_enable;
  logic        external_sense_select, por_request, irq;
  logic [3:0]  one_thr;
  logic        one_ext;
  logic [32:0] exp_q[$];
  int          fails = 0, checks = 0, cyc = 0;
  supply_supervisor_control dut (.ref_clk, .srst, .brownout_reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .comparator_low, .comparator_enable,
    .threshold_select, .external_sense_select, .por_request, .irq);
  supply_supervisor_control #(.SINGLE_LEVEL(1'b1)) dut_single (.ref_clk, .srst, .brownout_reset,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready(), .prdata(), .pslverr(),
    .comparator_low, .comparator_enable(), .threshold_select(one_thr),
    .external_sense_select(one_ext), .por_request(), .irq());
  comparator_model model (.comparator_enable, .threshold_select, .external_sense_select,
    .supply_level(supply), .ext_low, .comparator_low);
  initial forever #10 ref_clk = ~ref_clk;
  task check(input string nm, input logic [32:0] s, input logic [32:0] e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task give_verdict();
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'($urandom), d});
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task run(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk)
    if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0)
      check("read", {pslverr, prdata}, exp_q.pop_front());
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      fails++;
      give_verdict();
    end
  end
  initial
  begin
    void'($urandom(61));
    run(4);
    srst <= 1'b0;
    brownout_reset <= 1'b0;
    rd(CTRL_ADDR, 33'h0);
    rd(IRQ_STATUS_ADDR, 33'h0);
    rd(IRQ_MASK_ADDR, 33'h0);
    rd(12'h200, 33'h1_0000_0000);
    wr(CTRL_ADDR, 8'h04);
    rd(CTRL_ADDR, 33'h0);
    wr(CTRL_ADDR, 8'h80);
    supply <= 4'h0;
    run(20);
    check("enable", {comparator_enable, threshold_select}, 33'h18);
    rd(CTRL_ADDR, 33'h82);
    run(SETTLE_CYCLES);
    rd(CTRL_ADDR, 33'h87);
    rd(IRQ_STATUS_ADDR, 33'h3);
    rd(IRQ_STATUS_ADDR, 33'h0);
    supply <= 4'hF;
    run(5);
    rd(CTRL_ADDR, 33'h85);
    wr(CTRL_ADDR, 8'h80);
    rd(CTRL_ADDR, 33'h84);
    supply <= 4'h0;
    run(5);
    wr(CTRL_ADDR, 8'h80);
    rd(CTRL_ADDR, 33'h87);
    wr(CTRL_ADDR, 8'h48);
    run(5);
    check("por masked", {por_request, irq}, 33'h2);
    wr(IRQ_MASK_ADDR, 8'h07);
    run(3);
    check("irq", irq, 33'h1);
    supply <= 4'hF;
    run(6);
    check("por off", por_request, 33'h0);
    rd(IRQ_STATUS_ADDR, 33'h5);
    run(3);
    check("irq clear", irq, 33'h0);
    for (int l = 1; l < 16; l++)
    begin
      wr(CTRL_ADDR, {4'(l), 4'h0});
      run(2);
      check("level", {threshold_select, external_sense_select}, 33'({4'(l), l == 15}));
      check("single level", {one_thr, one_ext}, 33'h2);
    end
    ext_low <= 1'b1;
    run(6);
    rd(CTRL_ADDR, 33'hF7);
    ext_low <= 1'b0;
    wr(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h20);
    run(20);
    wr(CTRL_ADDR, 8'h20);
    rd(CTRL_ADDR, 33'h24);
    srst <= 1'b1;
    run(2);
    srst <= 1'b0;
    rd(CTRL_ADDR, 33'h24);
    brownout_reset <= 1'b1;
    run(2);
    brownout_reset <= 1'b0;
    rd(CTRL_ADDR, 33'h0);
    check("off", comparator_enable, 33'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
